// ===== core/scr_pkg.sv
/*
 Constants for the system control register block: offsets, bit positions,
 fixed reserved values and reset value.
 Assumes a single AHB-Lite master with 32-bit data and word accesses.
*/
// How it works
// - Bits 15 and 14 always read 1; writes to them are ignored.
// - Bit 12 always reads 1; writes leave it unchanged.
// - Bits 11 and 9 read 0; software must write 0 there.
// - Bit 10 reads 1; software must write 1 there.
// - Bit 13 selects MAC saturation, resets to 0, read/write.
// - Bit 8 enables on-chip RAM when 1, disables it when 0.
// - RAM enable takes its value 1 as soon as reset is asserted, and still holds 1 when it is released.
// - Bit 7 enables flash control register access, reset value 0.
// - Flash control registers are accessible only while bit 7 is 1.
// - Clearing bit 7 does not alter stored flash control contents.
// - Bits 6 to 2 read 0; software must write 0 there.
`default_nettype none
package scr_pkg;
    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [31:0] SCR_SYSCTL_OFFSET = 32'h0000_0000;
    localparam int SCR_WIDTH = 16;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int SCR_SAT_BIT = 13;
    localparam int SCR_RAM_BIT = 8;
    localparam int SCR_FLSH_BIT = 7;
    // Writable storage bits, fixed bits and their fixed values
    localparam logic [15:0] SCR_RW_MASK = 16'h2180;
    localparam logic [15:0] SCR_FIXED_VAL = 16'hd403;
    localparam logic [15:0] SCR_RESET = 16'hd503;
    // AHB-Lite encodings
    localparam logic [1:0] SCR_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] SCR_HTRANS_SEQ = 2'h3;
    localparam logic [2:0] SCR_HSIZE_WORD = 3'h2;
endpackage
`default_nettype wire

// ===== core/scr_system_control.sv
/*
 System control register behind an AHB-Lite slave port. Drives the MAC
 saturation select, on-chip RAM enable and flash control access enable.
 Assumes one clock hclk (25 MHz), asynchronous active-low hresetn, and a
 flash control register block that honours flash_ctl_reg_access_enable.
*/
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module scr_system_control
    import scr_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic mac_saturate_select,
    output logic onchip_ram_enable,
    output logic flash_ctl_reg_access_enable
);
    // ---------------------------------------------------------------
    // Address phase capture
    // ---------------------------------------------------------------
    logic wr_pend;
    logic rd_pend;
    logic hit_pend;
    logic next_wr_pend;
    logic next_rd_pend;
    logic next_hit_pend;
    logic [15:0] ctl;
    logic [15:0] next_ctl;
    logic [31:0] next_hrdata;
    logic addr_valid;
    logic addr_hit;

    // Valid transfer decode
    assign addr_valid = hsel && hready &&
        (htrans == SCR_HTRANS_NONSEQ || htrans == SCR_HTRANS_SEQ);
    assign addr_hit = (haddr == SCR_SYSCTL_OFFSET) && (hsize == SCR_HSIZE_WORD);

    // Latch the pending transfer for its data phase
    always_comb
    begin
        next_wr_pend = addr_valid && hwrite;
        next_rd_pend = addr_valid && !hwrite;
        next_hit_pend = addr_hit;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            hit_pend <= 1'b0;
        end
        else
        begin
            wr_pend <= next_wr_pend;
            rd_pend <= next_rd_pend;
            hit_pend <= next_hit_pend;
        end
    end

    // ---------------------------------------------------------------
    // Register storage
    // ---------------------------------------------------------------
    // Only the three control bits store; reserved bits are forced
    always_comb
    begin
        next_ctl = ctl;
        if (wr_pend && hit_pend)
        begin
            next_ctl = (hwdata[15:0] & SCR_RW_MASK) | SCR_FIXED_VAL;
        end
        next_ctl = (next_ctl & SCR_RW_MASK) | SCR_FIXED_VAL;
    end

    // Reset loads the documented word; RAM enable comes up as 1
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctl <= SCR_RESET;
        end
        else
        begin
            ctl <= next_ctl;
        end
    end

    // ---------------------------------------------------------------
    // Read data, one-cycle address-to-data with no wait states
    // ---------------------------------------------------------------
    always_comb
    begin
        next_hrdata = 32'h0000_0000;
        if (addr_valid && !hwrite && addr_hit)
        begin
            next_hrdata = {16'h0000, next_ctl};
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
        end
        else
        begin
            hrdata <= next_hrdata;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Control outputs straight from storage
    assign mac_saturate_select = ctl[SCR_SAT_BIT];
    assign onchip_ram_enable = ctl[SCR_RAM_BIT];
    // Flash block only gates access; its contents are untouched here
    assign flash_ctl_reg_access_enable = ctl[SCR_FLSH_BIT];

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    property p_ro_high;
        ctl[15:14] == 2'h3;
    endproperty
    a_ro_high: assert property (p_ro_high) else $error("bits 15:14 not 1");

    property p_bit12;
        ctl[12] == 1'b1;
    endproperty
    a_bit12: assert property (p_bit12) else $error("bit 12 not 1");

    property p_zero_bits;
        ctl[11] == 1'b0 && ctl[9] == 1'b0;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("bits 11 9 not 0");

    property p_bit10;
        ctl[10] == 1'b1;
    endproperty
    a_bit10: assert property (p_bit10) else $error("bit 10 not 1");

    property p_sat_write;
        wr_pend && hit_pend |=> mac_saturate_select == $past(hwdata[13]);
    endproperty
    a_sat_write: assert property (p_sat_write) else $error("saturate not written");

    property p_ram_write;
        wr_pend && hit_pend |=> onchip_ram_enable == $past(hwdata[8]);
    endproperty
    a_ram_write: assert property (p_ram_write) else $error("ram enable not written");

    property p_sat_hold;
        !(wr_pend && hit_pend) |=> $stable(mac_saturate_select);
    endproperty
    a_sat_hold: assert property (p_sat_hold) else $error("saturate moved");

    property p_ram_hold;
        !(wr_pend && hit_pend) |=> $stable(onchip_ram_enable);
    endproperty
    a_ram_hold: assert property (p_ram_hold) else $error("ram enable moved");

    property p_flsh_write;
        wr_pend && hit_pend |=> flash_ctl_reg_access_enable == $past(hwdata[7]);
    endproperty
    a_flsh_write: assert property (p_flsh_write) else $error("flash enable not written");

    property p_no_wait;
        hreadyout == 1'b1;
    endproperty
    a_no_wait: assert property (p_no_wait) else $error("wait state inserted");

    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("error response");

    property p_rd_idle;
        !(addr_valid && !hwrite && addr_hit) |=> hrdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");

    property p_fixed;
        (ctl & ~SCR_RW_MASK) == SCR_FIXED_VAL;
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed bits wrong");

    property p_flsh_hold;
        !(wr_pend && hit_pend) |=> $stable(flash_ctl_reg_access_enable);
    endproperty
    a_flsh_hold: assert property (p_flsh_hold) else $error("flash enable moved");

    property p_low_zero;
        ctl[6:2] == 5'h00 && ctl[1:0] == 2'h3;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("low bits wrong");

    property p_read_back;
        addr_valid && !hwrite && addr_hit && !(wr_pend && hit_pend)
            |=> hrdata == {16'h0000, $past(ctl)};
    endproperty
    a_read_back: assert property (p_read_back) else $error("read data mismatch");

    c_write: cover property (wr_pend && hit_pend);
    c_read: cover property (rd_pend && hit_pend);
    c_ram_off: cover property (!onchip_ram_enable);
    c_sat_on: cover property (mac_saturate_select);
    c_flsh_on: cover property (flash_ctl_reg_access_enable && mac_saturate_select);
endmodule
`default_nettype wire

// ===== test/system_control_register_bench.sv
/*
 Self-checking bench for the system control register block.
 Assumes one AHB-Lite master (this bench), hready fed back from hreadyout.
*/
`timescale 1ns/1ps
`default_nettype none
module system_control_register_bench
    import scr_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic sat, ram, fl;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd, wd;
    int num_errors = 0;
    int n_compared = 0;
    // One slave, so its hreadyout is the bus hready
    assign hready = hreadyout;
    scr_system_control dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .mac_saturate_select(sat),
        .onchip_ram_enable(ram), .flash_ctl_reg_access_enable(fl));
    // ----------------------------------------
    // Clock, watchdog and verdict
    // ----------------------------------------
    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    task wrap_up;
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge hclk);
        num_errors++;
        wrap_up;
    end
    // ----------------------------------------
    // Bus cycle, expectations and compares
    // ----------------------------------------
    // Address phase held until hready, then data phase; read data at its end
    task bus(input logic [31:0] a, input logic w, input logic [2:0] s,
             input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= SCR_HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= s;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // Fixed reserved pattern plus the three stored controls
    function automatic logic [31:0] exp_rd(input logic [31:0] v);
        return {16'h0000, 16'hd403 | (v[15:0] & 16'h2180)};
    endfunction
    task chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask
    // Controls checked mid-cycle, once register updates have landed
    task chk_out(input logic [2:0] exp);
        @(negedge hclk);
        n_compared++;
        if ({sat, ram, fl} !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: controls %b, wanted %b", $time,
                     {sat, ram, fl}, exp);
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = SCR_HSIZE_WORD;
        hwdata = 32'h0;
        void'($urandom(32'h34db));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        chk_out(3'b010);
        bus(SCR_SYSCTL_OFFSET, 1'b0, SCR_HSIZE_WORD, 32'h0);
        chk_word(rd, 32'h0000_d503);
        // Corners: all controls set, all cleared, then random; no RAM access runs
        for (int i = 0; i < 24; i++)
        begin
            wd = (i == 0) ? 32'hffff_f583 : (i == 1) ? 32'h0000_0403 :
                 (($urandom & 32'hffff_f180) | 32'h0000_0403);
            bus(SCR_SYSCTL_OFFSET, 1'b1, SCR_HSIZE_WORD, wd);
            chk_out({wd[13], wd[8], wd[7]});
            bus(SCR_SYSCTL_OFFSET, 1'b0, SCR_HSIZE_WORD, $urandom);
            chk_word(rd, exp_rd(wd));
            // Unmapped address and byte size must leave the register alone
            bus(32'h0000_0004, 1'b1, SCR_HSIZE_WORD, ~wd);
            bus(SCR_SYSCTL_OFFSET, 1'b1, 3'h0, ~wd);
            bus(32'h0000_0004, 1'b0, SCR_HSIZE_WORD, 32'h0);
            chk_word(rd, 32'h0);
            bus(SCR_SYSCTL_OFFSET, 1'b0, SCR_HSIZE_WORD, 32'h0);
            chk_word(rd, exp_rd(wd));
        end
        // Second reset in mid-run restores the initial word
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        chk_out(3'b010);
        bus(SCR_SYSCTL_OFFSET, 1'b0, SCR_HSIZE_WORD, 32'h0);
        chk_word(rd, 32'h0000_d503);
        wrap_up;
    end
endmodule
`default_nettype wire
